// File: hdl/txhw_cfg.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef TXHW_CFG_SVH
`define TXHW_CFG_SVH
`define TXHW_ADDR_W 8
`define TXHW_OFS_TX_CFG 8'h70
`define TXHW_OFS_HARDWARE_CONFIG 8'h74
`define TXHW_BIT_TXS_FLUSH 15
`define TXHW_BIT_TXD_FLUSH 14
`define TXHW_BIT_KEEP_SEND 2
`define TXHW_BIT_TX_ON 1
`define TXHW_BIT_STOP 0
`define TXHW_BIT_PORT_END 29
`define TXHW_BIT_DSEL_END 28
`define TXHW_BIT_STRAP 24
`define TXHW_BIT_MUST_SET 20
`define TXHW_FIFO_LSB 16
`define TXHW_BIT_SW_RESET_TIMEOUT 1
`define TXHW_BIT_SW_RESET_BIT 0
`define TXHW_FIFO_RST 4'h5
`define TXHW_TX_STS_BYTES 15'h0200
`define TXHW_TOTAL_BYTES 15'h4000
`define TXHW_KB_SHIFT 10
// Time allowed for the link clocks to show activity during a soft reset.
`define TXHW_SW_RESET_BIT_WAIT_NS 1000
`define TXHW_CLK_NS 10
`define TXHW_SW_RESET_BIT_WAIT_CYC (`TXHW_SW_RESET_BIT_WAIT_NS / `TXHW_CLK_NS)
`endif

// File: hdl/txhw_pkg.sv
// Types shared by the transmit and hardware configuration block.
package txhw_pkg;
  // Soft reset sequencer states.
  typedef enum logic [1:0] {
    TXHW_SR_IDLE = 2'b00,
    TXHW_SR_WAIT = 2'b01,
    TXHW_SR_DONE = 2'b10
  } txhw_sr_t;
  // Transmitter run states.
  typedef enum logic [1:0] {
    TXHW_TX_OFF = 2'b00,
    TXHW_TX_RUN = 2'b01,
    TXHW_TX_DRAIN = 2'b10
  } txhw_tx_t;
endpackage : txhw_pkg

// File: hdl/txhw_regs.sv
// Transmit configuration and hardware configuration register bank.
//
// Function
// - TX status flush zeroes pointers, self-clears.
// - TX data flush zeroes pointers, self-clears.
// - Status full suspends transmit unless keep-sending.
// - Status full interrupt ignores keep-sending bit.
// - Transmit enable sends queued data.
// - Enable clears after stop and halt.
// - Stop finishes frame, clears when halted.
// - Writes to stop ignored while set.
// - Port byte-order bit selects port endianness.
// - Direct-select bit selects direct-access endianness.
// - Byte-order bits survive software reset.
// - Strap bit is read-only strap level.
// - Buffer size field, 1KB units, reset 5.
// - Status buffer 512 bytes, data gets rest.
// - Receive gets 16KB minus transmit allocation.
// - Reset without link clocks times out, flags.
// - Software reset bit starts reset, self-clears.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "txhw_cfg.svh"
module txhw_regs
  import txhw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`TXHW_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic crossover_strap,
  input wire logic link_clk_alive,
  input wire logic tx_sts_full,
  input wire logic frame_done,
  output logic tx_active,
  output logic tx_sts_ptr_clr,
  output logic tx_data_ptr_clr,
  output logic tx_sts_full_irq,
  output logic port_byte_order,
  output logic direct_select_byte_order,
  output logic [14:0] tx_data_bytes,
  output logic [14:0] tx_sts_bytes,
  output logic [14:0] rx_total_bytes,
  output logic sw_reset_pulse
);

  // All state of the bank in one word.
  typedef struct packed {
    logic [31:0] rdata;
    logic keep_send;
    logic tx_on;
    logic stop;
    txhw_tx_t tx_st;
    logic sts_clr;
    logic dat_clr;
    logic port_end;
    logic dsel_end;
    logic strap;
    logic must_set;
    logic [3:0] fifo_sz;
    logic sw_reset_timeout;
    txhw_sr_t sr_st;
    logic [7:0] sr_cnt;
    logic sw_reset_bit_pulse;
  } txhw_state_t;

  txhw_state_t st_ff;
  txhw_state_t nxt_st;
  logic strap_s; // Strap level after synchronising.
  logic alive_s; // Link clock activity after synchronising.
  logic wr_tx; // Write to the transmit configuration word.
  logic wr_hw; // Write to the hardware configuration word.
  logic [31:0] tx_word; // Read view of the transmit word.
  logic [31:0] hw_word; // Read view of the hardware word.

  // Strap and link activity come from pins and are synchronised.
  txhw_sync2 u_sync_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(crossover_strap),
    .dout(strap_s)
  );
  txhw_sync2 u_sync_alive (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(link_clk_alive),
    .dout(alive_s)
  );

  assign wr_tx = reg_wr && (reg_addr == `TXHW_OFS_TX_CFG);
  assign wr_hw = reg_wr && (reg_addr == `TXHW_OFS_HARDWARE_CONFIG);

  // Read views; reserved bits are zero and flush bits read zero.
  always_comb begin
    tx_word = 32'h0;
    tx_word[`TXHW_BIT_KEEP_SEND] = st_ff.keep_send;
    tx_word[`TXHW_BIT_TX_ON] = st_ff.tx_on;
    tx_word[`TXHW_BIT_STOP] = st_ff.stop;
    hw_word = 32'h0;
    hw_word[`TXHW_BIT_PORT_END] = st_ff.port_end;
    hw_word[`TXHW_BIT_DSEL_END] = st_ff.dsel_end;
    hw_word[`TXHW_BIT_STRAP] = st_ff.strap;
    hw_word[`TXHW_BIT_MUST_SET] = st_ff.must_set;
    hw_word[`TXHW_FIFO_LSB+3:`TXHW_FIFO_LSB] = st_ff.fifo_sz;
    hw_word[`TXHW_BIT_SW_RESET_TIMEOUT] = st_ff.sw_reset_timeout;
    hw_word[`TXHW_BIT_SW_RESET_BIT] = (st_ff.sr_st == TXHW_SR_WAIT);
  end

  // Next-state logic for the whole bank.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sts_clr = 1'b0;
    nxt_st.dat_clr = 1'b0;
    nxt_st.sw_reset_bit_pulse = 1'b0;
    // Read data stand in the cycle after the strobe only.
    if (reg_rd) begin
      if (reg_addr == `TXHW_OFS_TX_CFG) begin
        nxt_st.rdata = tx_word;
      end else if (reg_addr == `TXHW_OFS_HARDWARE_CONFIG) begin
        nxt_st.rdata = hw_word;
      end else begin
        nxt_st.rdata = 32'h0;
      end
    end else begin
      nxt_st.rdata = 32'h0;
    end
    // The strap level is tracked each cycle; software cannot write it.
    nxt_st.strap = strap_s;
    // Transmit configuration writes.
    if (wr_tx) begin
      nxt_st.sts_clr = reg_wdata[`TXHW_BIT_TXS_FLUSH];
      nxt_st.dat_clr = reg_wdata[`TXHW_BIT_TXD_FLUSH];
      nxt_st.keep_send = reg_wdata[`TXHW_BIT_KEEP_SEND];
      nxt_st.tx_on = reg_wdata[`TXHW_BIT_TX_ON];
      if (!st_ff.stop) begin
        nxt_st.stop = reg_wdata[`TXHW_BIT_STOP];
      end
    end
    // Transmitter sequencing: a stop drains the current frame.
    case (st_ff.tx_st)
      TXHW_TX_OFF: begin
        if (st_ff.stop) begin
          nxt_st.stop = 1'b0;
          nxt_st.tx_on = 1'b0;
        end else if (st_ff.tx_on) begin
          nxt_st.tx_st = TXHW_TX_RUN;
        end
      end
      TXHW_TX_RUN: begin
        if (st_ff.stop) begin
          nxt_st.tx_st = TXHW_TX_DRAIN;
        end else if (!st_ff.tx_on) begin
          nxt_st.tx_st = TXHW_TX_OFF;
        end
      end
      TXHW_TX_DRAIN: begin
        if (frame_done) begin
          nxt_st.tx_st = TXHW_TX_OFF;
        end
      end
      default: begin
        nxt_st.tx_st = TXHW_TX_OFF;
      end
    endcase
    // Hardware configuration writes; the strap and timeout are read-only.
    if (wr_hw) begin
      nxt_st.port_end = reg_wdata[`TXHW_BIT_PORT_END];
      nxt_st.dsel_end = reg_wdata[`TXHW_BIT_DSEL_END];
      nxt_st.must_set = reg_wdata[`TXHW_BIT_MUST_SET];
      nxt_st.fifo_sz = reg_wdata[`TXHW_FIFO_LSB+3:`TXHW_FIFO_LSB];
    end
    // Soft reset sequencer: waits for link clocks or times out.
    case (st_ff.sr_st)
      TXHW_SR_IDLE: begin
        if (wr_hw && reg_wdata[`TXHW_BIT_SW_RESET_BIT]) begin
          nxt_st.sr_st = TXHW_SR_WAIT;
          nxt_st.sr_cnt = 8'h00;
          nxt_st.sw_reset_timeout = 1'b0;
        end
      end
      TXHW_SR_WAIT: begin
        if (alive_s) begin
          nxt_st.sr_st = TXHW_SR_DONE;
        end else if (st_ff.sr_cnt == 8'(`TXHW_SW_RESET_BIT_WAIT_CYC - 1)) begin
          nxt_st.sw_reset_timeout = 1'b1;
          nxt_st.sr_st = TXHW_SR_IDLE;
        end else begin
          nxt_st.sr_cnt = st_ff.sr_cnt + 8'h01;
        end
      end
      TXHW_SR_DONE: begin
        // Reset the bank except the byte-order bits.
        nxt_st.sw_reset_bit_pulse = 1'b1;
        nxt_st.sr_st = TXHW_SR_IDLE;
        nxt_st.keep_send = 1'b0;
        nxt_st.tx_on = 1'b0;
        nxt_st.stop = 1'b0;
        nxt_st.tx_st = TXHW_TX_OFF;
        nxt_st.must_set = 1'b0;
        nxt_st.fifo_sz = `TXHW_FIFO_RST;
        nxt_st.sts_clr = 1'b1;
        nxt_st.dat_clr = 1'b1;
      end
      default: begin
        nxt_st.sr_st = TXHW_SR_IDLE;
      end
    endcase
  end

  // Register the state; reset values are constants only.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.fifo_sz <= `TXHW_FIFO_RST;
      st_ff.tx_st <= TXHW_TX_OFF;
      st_ff.sr_st <= TXHW_SR_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs.
  assign reg_rdata = st_ff.rdata;
  // Halted on a full status buffer unless keep-sending is set.
  assign tx_active = (st_ff.tx_st != TXHW_TX_OFF) &&
                     (st_ff.keep_send || !tx_sts_full);
  assign tx_sts_full_irq = tx_sts_full;
  assign tx_sts_ptr_clr = st_ff.sts_clr;
  assign tx_data_ptr_clr = st_ff.dat_clr;
  assign port_byte_order = st_ff.port_end;
  assign direct_select_byte_order = st_ff.dsel_end;
  assign sw_reset_pulse = st_ff.sw_reset_bit_pulse;
  // Memory split derived from the size field.
  assign tx_sts_bytes = `TXHW_TX_STS_BYTES;
  assign tx_data_bytes = 15'({st_ff.fifo_sz, 10'h000}) - `TXHW_TX_STS_BYTES;
  assign rx_total_bytes = `TXHW_TOTAL_BYTES - 15'({st_ff.fifo_sz, 10'h000});

  // A status flush write gives a pointer clear in the next cycle.
  chk_flush_pulse: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    wr_tx && reg_wdata[`TXHW_BIT_TXS_FLUSH] |=> tx_sts_ptr_clr)
    else $error("status flush pulse missing");
  // The status clear never outlives its cause, so the bit self-clears.
  chk_flush_cause: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_sts_ptr_clr |-> $past(wr_tx && reg_wdata[`TXHW_BIT_TXS_FLUSH])
    || $past(st_ff.sr_st == TXHW_SR_DONE))
    else $error("status flush pulse not cleared");
  // A data flush write gives a pointer clear in the next cycle.
  chk_data_flush: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    wr_tx && reg_wdata[`TXHW_BIT_TXD_FLUSH] |=> tx_data_ptr_clr)
    else $error("data flush pulse missing");
  // The data clear never outlives its cause, so the bit self-clears.
  chk_data_cause: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_data_ptr_clr |-> $past(wr_tx && reg_wdata[`TXHW_BIT_TXD_FLUSH])
    || $past(st_ff.sr_st == TXHW_SR_DONE))
    else $error("data flush pulse not cleared");
  // A full status buffer halts the sender unless keep-sending is set.
  chk_full_hold: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_sts_full && !st_ff.keep_send |-> !tx_active)
    else $error("transmit ran on full status");
  // The full interrupt follows the buffer level in either mode.
  chk_irq_full: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_sts_full_irq == tx_sts_full)
    else $error("full interrupt depends on mode");
  // An enabled idle transmitter starts sending in the next cycle.
  chk_run_start: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.tx_on && !st_ff.stop && st_ff.tx_st == TXHW_TX_OFF
    && st_ff.sr_st != TXHW_SR_DONE |=> st_ff.tx_st == TXHW_TX_RUN)
    else $error("enabled transmitter did not start");
  // Once halted with a stop pending, both stop and enable clear.
  chk_stop_clear: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.stop && st_ff.tx_st == TXHW_TX_OFF
    |=> !st_ff.stop && !st_ff.tx_on)
    else $error("stop did not clear enable");
  // The stop request stands until the current frame has ended.
  chk_stop_drain: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.tx_st == TXHW_TX_DRAIN && !frame_done |=> st_ff.stop)
    else $error("stop cleared mid frame");
  // A pending stop cannot be written away while the sender runs.
  chk_stop_locked: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.stop && st_ff.tx_st != TXHW_TX_OFF && st_ff.sr_st != TXHW_SR_DONE
    |=> st_ff.stop)
    else $error("stop bit changed by write");
  // Both byte-order bits keep their values through a soft reset.
  chk_endian_keep: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    sw_reset_pulse |-> $stable(port_byte_order)
    && $stable(direct_select_byte_order))
    else $error("byte order lost in reset");
  // A soft reset that sees no link clocks ends with the flag set.
  chk_sw_reset_timeout: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.sr_st == TXHW_SR_WAIT && !alive_s
    && st_ff.sr_cnt == 8'(`TXHW_SW_RESET_BIT_WAIT_CYC - 1) |=> st_ff.sw_reset_timeout)
    else $error("soft reset timeout not flagged");
  // A completed soft reset pulses once and its bit reads zero again.
  chk_sw_reset_bit_done: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    st_ff.sr_st == TXHW_SR_DONE |=> st_ff.sr_st == TXHW_SR_IDLE && sw_reset_pulse)
    else $error("soft reset bit did not self-clear");
  // Reserved and flush bits of the transmit word read as zero.
  chk_tx_rsvd: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $past(reg_rd && reg_addr == `TXHW_OFS_TX_CFG) |-> reg_rdata[31:3] == 29'h0)
    else $error("transmit word reserved bits set");
endmodule : txhw_regs

// File: hdl/txhw_sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module txhw_sync2 (
  core_clk,
  rst_n,
  din,
  dout
);
  input wire logic core_clk;
  input wire logic rst_n;
  input wire logic din;
  output logic dout;

  // Both stages as one state word.
  typedef struct packed {
    logic s1;
    logic s2;
  } txhw_sync_t;

  txhw_sync_t st_ff;
  txhw_sync_t nxt_st;

  // The first stage is read only by the second stage.
  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  // Synchronous reset clears both stages.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;
endmodule : txhw_sync2

// File: tb/tx_control_hw_config_test.sv
// Self-checking bench for the transmit and hardware configuration block.
`timescale 1ns/1ps
`include "txhw_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tx_control_hw_config_test;
  logic core_clk, rst_n, reg_wr, reg_rd, strap, alive, sts_full, frame_done;
  logic tx_active, sts_clr, data_clr, full_irq, pe_o, de_o, sw_reset_bit_p, pe, de;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdat;
  logic [14:0] txd_b, txs_b, rx_b;
  integer n_fail = 0, samples_checked = 0, seed = 32'hf6807484, i, sz, k;

  // Free-running core clock of 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  txhw_host u_txhw_host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  txhw_regs u_txhw_regs (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crossover_strap(strap),
    .link_clk_alive(alive), .tx_sts_full(sts_full),
    .frame_done(frame_done), .tx_active(tx_active),
    .tx_sts_ptr_clr(sts_clr), .tx_data_ptr_clr(data_clr),
    .tx_sts_full_irq(full_irq), .port_byte_order(pe_o),
    .direct_select_byte_order(de_o), .tx_data_bytes(txd_b),
    .tx_sts_bytes(txs_b), .rx_total_bytes(rx_b), .sw_reset_pulse(sw_reset_bit_p));

  // Expected hardware configuration word built from its fields.
  function automatic logic [31:0] exp_hw(input logic p, d, s, m,
      input logic [3:0] z, input logic to);
    exp_hw = {2'b00, p, d, 3'b000, s, 3'b000, m, z, 14'h0000, to, 1'b0};
  endfunction : exp_hw

  // Checks the buffer split that follows from a size field value.
  task automatic chk_split(input logic [3:0] z);
    `CHK("tx_data_bytes", 15'(z * 1024 - 512), txd_b)
    `CHK("tx_sts_bytes", 15'h0200, txs_b)
    `CHK("rx_total_bytes", 15'(16384 - z * 1024), rx_b)
  endtask : chk_split

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Main sequence of tests.
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    alive = 1'b1;
    sts_full = 1'b0;
    frame_done = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values, the read-only strap and an unmapped address.
    u_txhw_host.rd(8'h70, rdat);
    `CHK("transmit_config", 32'h0, rdat)
    u_txhw_host.rd(8'h74, rdat);
    `CHK("hardware_config", exp_hw(0, 0, 1, 0, 5, 0), rdat)
    chk_split(4'h5);
    u_txhw_host.rd(8'h40, rdat);
    `CHK("unmapped", 32'h0, rdat)
    $display("test reset_values done");
    // Every legal size with random byte order and reserved bits set.
    for (sz = 2; sz <= 14; sz++) begin
      pe = 1'($random(seed));
      de = 1'($random(seed));
      u_txhw_host.gap = $random(seed) & 3;
      rdat = exp_hw(pe, de, 1'b0, 1'b1, sz[3:0], 1'b0);
      u_txhw_host.wr(8'h74, rdat | 32'hcee0fffc);
      u_txhw_host.rd(8'h74, rdat);
      `CHK("hardware_config", exp_hw(pe, de, 1, 1, sz[3:0], 0), rdat)
      `CHK("port_byte_order", pe, pe_o)
      `CHK("direct_select_byte_order", de, de_o)
      chk_split(sz[3:0]);
    end
    u_txhw_host.gap = 0;
    $display("test size_and_order done");
    // Transmitter runs; a full status buffer stops it unless kept going.
    for (k = 0; k < 2; k++) begin
      u_txhw_host.wr(8'h70, {29'h0, k[0], 2'b10});
      repeat (3) @(posedge core_clk);
      #1 `CHK("tx_active", 1'b1, tx_active)
      @(posedge core_clk);
      sts_full <= 1'b1;
      #1 `CHK("tx_active_full", k[0], tx_active)
      `CHK("tx_sts_full_irq", 1'b1, full_irq)
      @(posedge core_clk);
      sts_full <= 1'b0;
    end
    $display("test transmit done");
    // Stop waits for the frame end; clearing it meanwhile is ignored.
    u_txhw_host.wr(8'h70, 32'h7);
    u_txhw_host.wr(8'h70, 32'h6);
    u_txhw_host.rd(8'h70, rdat);
    `CHK("stop_held", 32'h7, rdat)
    @(posedge core_clk);
    frame_done <= 1'b1;
    @(posedge core_clk);
    frame_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("tx_active_off", 1'b0, tx_active)
    u_txhw_host.rd(8'h70, rdat);
    `CHK("transmit_config", 32'h4, rdat)
    $display("test stop done");
    // Each flush bit gives one pointer clear pulse and reads back zero.
    for (k = 0; k < 2; k++) begin
      u_txhw_host.wr(8'h70, (32'h8000 >> k) | 32'h4);
      i = 0;
      repeat (3) begin
        #1 i += k ? data_clr : sts_clr;
        @(posedge core_clk);
      end
      `CHK("flush_pulse_cycles", 1, i)
      u_txhw_host.rd(8'h70, rdat);
      `CHK("transmit_config", 32'h4, rdat)
    end
    $display("test flush done");
    // Soft reset without link clocks times out and raises the flag.
    @(posedge core_clk);
    alive <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdat = exp_hw(pe, de, 1'b0, 1'b1, 4'he, 1'b0) | 32'h1;
    u_txhw_host.wr(8'h74, rdat);
    repeat (`TXHW_SW_RESET_BIT_WAIT_CYC + 10) @(posedge core_clk);
    u_txhw_host.rd(8'h74, rdat);
    `CHK("sw_reset_timeout", exp_hw(pe, de, 1, 1, 14, 1), rdat)
    // Link restored, strap changed, then the reset is asked again.
    @(posedge core_clk);
    alive <= 1'b1;
    strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdat = exp_hw(pe, de, 1'b0, 1'b1, 4'he, 1'b0) | 32'h1;
    u_txhw_host.wr(8'h74, rdat);
    i = 0;
    while (sw_reset_bit_p !== 1'b1 && i < 200) begin
      @(posedge core_clk);
      #1 i++;
    end
    if (i == 200) begin
      n_fail++;
      $display("[FAIL] sw_reset_pulse expected 1 seen 0");
    end else begin
      `CHK("sw_reset_bit_flush", 2'b11, {sts_clr, data_clr})
      repeat (2) @(posedge core_clk);
      u_txhw_host.rd(8'h74, rdat);
      `CHK("hardware_config_after", exp_hw(pe, de, 0, 0, 5, 0), rdat)
      u_txhw_host.rd(8'h70, rdat);
      `CHK("tx_cfg_after", 32'h0, rdat)
      chk_split(4'h5);
    end
    $display("test soft_reset done");
    final_report;
  end
endmodule : tx_control_hw_config_test

// File: tb/txhw_host.sv
// Host processor model that drives the register port of the block.
`timescale 1ns/1ps
`include "txhw_cfg.svh"
module txhw_host (
  input wire logic core_clk,
  output logic [`TXHW_ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Idle clocks before each access, so the host can be prompt or slow.
  int unsigned gap = 0;

  // The bus starts idle with both strobes low.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write cycle; the data are scrambled after it so none linger.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : txhw_host
